// >>> hw/cwd_pkg.sv
/*
 * Constants and carrier types for the bus wake-up and line diagnosis block.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
package cwd_pkg;

    // ==========================================================
    // Chip modes and wake-up sequence states
    typedef enum logic [1:0] {
        CWD_CHIP_NORMAL = 2'h0,
        CWD_CHIP_STANDBY = 2'h1,
        CWD_CHIP_STOP = 2'h3,
        CWD_CHIP_SLEEP = 2'h2
    } cwd_chip_mode_type;

    typedef enum logic [1:0] {
        CWD_WS_IDLE = 2'h0,
        CWD_WS_REG_ON = 2'h1,
        CWD_WS_RELEASE = 2'h3
    } cwd_wake_state_type;

    // ==========================================================
    // Bit positions in the bus status register
    localparam int CWD_BUS_REG_W = 8;
    localparam int CWD_BIT_WAKE = 3;
    localparam int CWD_BIT_FAIL = 2;
    localparam int CWD_BIT_UNID = 1;

    // Failure code positions in line-specific registers
    localparam int CWD_LINE_W = 3;
    localparam int CWD_LN_GND = 0;
    localparam int CWD_LN_BAT = 1;
    localparam int CWD_LN_LOG = 2;

    // ==========================================================
    // Timing
    localparam int CWD_CLK_MHZ = 100;
    localparam int CWD_REG_SETTLE_US = 10;
    localparam int CWD_REG_SETTLE_CYC = CWD_REG_SETTLE_US * CWD_CLK_MHZ;
    localparam int CWD_ID_CYCLES = 5;
    localparam logic [2:0] CWD_CNT_ZERO = 3'h0;

    // ==========================================================
    // Comparator set, one bit per line and threshold
    typedef struct packed {
        logic low_line_ground_cmp;
        logic high_line_ground_cmp;
        logic low_line_battery_cmp;
        logic high_line_battery_cmp;
        logic low_line_logic_supply_cmp;
        logic high_line_logic_supply_cmp;
    } cwd_cmp_type;

    localparam cwd_cmp_type CWD_HEALTHY_REC = 6'h30;
    localparam cwd_cmp_type CWD_HEALTHY_DOM = 6'h10;

    // Failure classes
    typedef struct packed {
        logic [CWD_LINE_W-1:0] low_line;
        logic [CWD_LINE_W-1:0] high_line;
    } cwd_fail_type;

endpackage

// >>> hw/cwd_sync.sv
/*
 * Two-flop synchroniser for a vector of comparator levels.
 * Assumes inputs are quasi-static analog comparator outputs.
 */
`timescale 1ns/1ps
module cwd_sync #(
    parameter int WIDTH = 6
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } cwd_sync_state_type;

    cwd_sync_state_type state_q;
    cwd_sync_state_type state_d;

    initial begin
        if (WIDTH < 1) begin
            $error("cwd_sync: WIDTH must be positive");
        end
    end

    always_comb begin
        state_d.meta = async_i;
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.sync;
endmodule

// >>> hw/cwd_top.sv
/*
 * Bus wake-up reporting and bus line short diagnosis.
 * Assumes mode inputs come from the register logic, a register read strobe,
 * and raw comparator levels plus the driver phase from the transceiver.
 */
`timescale 1ns/1ps
module cwd_top #(
    parameter int SETTLE_CYCLES = cwd_pkg::CWD_REG_SETTLE_CYC,
    parameter int ID_CYCLES = cwd_pkg::CWD_ID_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire cwd_pkg::cwd_chip_mode_type chip_mode_i,
    input wire logic bus_sleep_i,
    input wire logic bus_wake_enable_i,
    input wire logic transceive_mode_i,
    input wire logic bus_wake_event_i,
    input wire logic other_wake_event_i,
    input wire logic bus_reg_read_i,
    input wire logic driver_dominant_i,
    input wire logic phase_valid_i,
    input wire cwd_pkg::cwd_cmp_type cmp_raw_i,
    output logic main_reg_on_o,
    output logic host_reset_n_o,
    output logic irq_pulse_o,
    output logic [cwd_pkg::CWD_BUS_REG_W-1:0] bus_status_o,
    output logic [cwd_pkg::CWD_LINE_W-1:0] timer_diag_registers_o,
    output logic [cwd_pkg::CWD_LINE_W-1:0] low_power_ctrl_register_o
);
    localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

    initial begin
        if (SETTLE_CYCLES < 1 || ID_CYCLES < 1 || ID_CYCLES > 7) begin
            $error("cwd_top: unsupported SETTLE_CYCLES or ID_CYCLES");
        end
    end

    typedef struct packed {
        cwd_pkg::cwd_wake_state_type wstate;
        logic [SET_W-1:0] settle;
        logic main_reg_on;
        logic host_reset_n;
        logic irq;
        logic wake_flag;
        logic tx_seen;
        cwd_pkg::cwd_cmp_type rec_smp;
        logic rec_ok;
        logic rec_fail;
        logic dom_fail;
        cwd_pkg::cwd_fail_type cand;
        logic [2:0] match_cnt;
        logic fail;
        logic unid;
        cwd_pkg::cwd_fail_type ident;
    } cwd_state_type;

    cwd_state_type state_q;
    cwd_state_type state_d;
    cwd_pkg::cwd_cmp_type cmp_s;

    // ==========================================================
    // Comparator synchroniser
    cwd_sync #(
        .WIDTH($bits(cwd_pkg::cwd_cmp_type))
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(cmp_raw_i),
        .sync_o(cmp_s)
    );

    // ==========================================================
    // Decode one recessive/dominant pair into line failures
    function automatic cwd_pkg::cwd_fail_type decode_pair(
        input cwd_pkg::cwd_cmp_type rec,
        input cwd_pkg::cwd_cmp_type dom
    );
        cwd_pkg::cwd_fail_type f;
        f = '0;
        if (!rec.low_line_ground_cmp && !rec.high_line_ground_cmp) begin
            if (!dom.high_line_ground_cmp) begin
                f.high_line[cwd_pkg::CWD_LN_GND] = 1'b1;
            end else if (!dom.low_line_ground_cmp) begin
                f.low_line[cwd_pkg::CWD_LN_GND] = 1'b1;
            end
        end
        if (rec.low_line_battery_cmp && rec.high_line_battery_cmp && dom.high_line_battery_cmp) begin
            if (dom.low_line_battery_cmp) begin
                f.low_line[cwd_pkg::CWD_LN_BAT] = 1'b1;
            end else begin
                f.high_line[cwd_pkg::CWD_LN_BAT] = 1'b1;
            end
        end
        if (rec.low_line_logic_supply_cmp && rec.high_line_logic_supply_cmp
            && dom.high_line_logic_supply_cmp) begin
            if (dom.low_line_logic_supply_cmp) begin
                f.low_line[cwd_pkg::CWD_LN_LOG] = 1'b1;
            end else begin
                f.high_line[cwd_pkg::CWD_LN_LOG] = 1'b1;
            end
        end
        return f;
    endfunction

    // Recessive-only failure check, line unknown
    function automatic logic rec_failed(input cwd_pkg::cwd_cmp_type rec);
        return (!rec.low_line_ground_cmp && !rec.high_line_ground_cmp)
            || (rec.low_line_battery_cmp && rec.high_line_battery_cmp)
            || (rec.low_line_logic_supply_cmp && rec.high_line_logic_supply_cmp);
    endfunction

    logic wake_any;
    logic in_stop;
    logic in_sleep;
    logic bus_report;
    cwd_pkg::cwd_fail_type pair_f;

    always_comb begin
        state_d = state_q;
        in_sleep = (chip_mode_i == cwd_pkg::CWD_CHIP_SLEEP);
        in_stop = (chip_mode_i == cwd_pkg::CWD_CHIP_STOP);
        bus_report = bus_sleep_i && bus_wake_enable_i && bus_wake_event_i;
        wake_any = bus_report || other_wake_event_i;
        pair_f = decode_pair(state_q.rec_smp, cmp_s);
        state_d.irq = 1'b0;

        // ======================================================
        // Wake-up reporting
        case (state_q.wstate)
            cwd_pkg::CWD_WS_IDLE: begin
                if (in_sleep) begin
                    state_d.main_reg_on = 1'b0;
                    state_d.host_reset_n = 1'b0;
                    if (wake_any) begin
                        state_d.main_reg_on = 1'b1;
                        state_d.settle = '0;
                        state_d.wstate = cwd_pkg::CWD_WS_REG_ON;
                    end
                end else begin
                    state_d.main_reg_on = 1'b1;
                    state_d.host_reset_n = 1'b1;
                end
            end
            cwd_pkg::CWD_WS_REG_ON: begin
                state_d.settle = state_q.settle + 1'b1;
                if (state_q.settle == SET_W'(SETTLE_CYCLES - 1)) begin
                    state_d.wstate = cwd_pkg::CWD_WS_RELEASE;
                end
            end
            cwd_pkg::CWD_WS_RELEASE: begin
                state_d.host_reset_n = 1'b1;
                if (!in_sleep) begin
                    state_d.wstate = cwd_pkg::CWD_WS_IDLE;
                end
            end
            default: begin
                state_d.wstate = cwd_pkg::CWD_WS_IDLE;
            end
        endcase

        if (in_stop && wake_any) begin
            state_d.irq = 1'b1;
        end

        // Flag clears after transceive mode then a read; new wake wins
        if (transceive_mode_i) begin
            if (state_q.wake_flag) begin
                state_d.tx_seen = 1'b1;
            end
        end else begin
            state_d.tx_seen = 1'b0;
        end
        if (state_q.tx_seen && transceive_mode_i && bus_reg_read_i) begin
            state_d.wake_flag = 1'b0;
            state_d.tx_seen = 1'b0;
        end
        if (bus_report && (in_stop || in_sleep
            || chip_mode_i == cwd_pkg::CWD_CHIP_NORMAL
            || chip_mode_i == cwd_pkg::CWD_CHIP_STANDBY)) begin
            state_d.wake_flag = 1'b1;
        end

        // ======================================================
        // Bus diagnosis
        if (phase_valid_i && !driver_dominant_i) begin
            state_d.rec_smp = cmp_s;
            state_d.rec_ok = 1'b1;
            state_d.rec_fail = rec_failed(cmp_s);
            if (rec_failed(cmp_s)) begin
                state_d.fail = 1'b1;
                if (state_q.ident == '0) begin
                    state_d.unid = 1'b1;
                end
            end else if (!state_q.dom_fail) begin
                state_d.fail = 1'b0;
                state_d.unid = 1'b0;
                state_d.match_cnt = cwd_pkg::CWD_CNT_ZERO;
                state_d.cand = '0;
                state_d.ident = '0;
            end
        end
        if (phase_valid_i && driver_dominant_i && state_q.rec_ok) begin
            state_d.rec_ok = 1'b0;
            state_d.dom_fail = (pair_f != '0) || (cmp_s != cwd_pkg::CWD_HEALTHY_DOM);
            if (pair_f != '0 && pair_f == state_q.cand) begin
                if (state_q.match_cnt != 3'(ID_CYCLES)) begin
                    state_d.match_cnt = state_q.match_cnt + 1'b1;
                end
            end else begin
                state_d.cand = pair_f;
                state_d.match_cnt = (pair_f != '0) ? 3'h1 : cwd_pkg::CWD_CNT_ZERO;
            end
            if (pair_f != '0 && state_d.match_cnt == 3'(ID_CYCLES)) begin
                state_d.ident = pair_f;
                state_d.unid = 1'b0;
            end
            if (state_d.dom_fail || state_q.rec_fail) begin
                state_d.fail = 1'b1;
            end else if (state_q.rec_smp == cwd_pkg::CWD_HEALTHY_REC) begin
                state_d.fail = 1'b0;
                state_d.unid = 1'b0;
                state_d.ident = '0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
            state_q.main_reg_on <= 1'b1;
            state_q.host_reset_n <= 1'b1;
            state_q.rec_smp <= cwd_pkg::CWD_HEALTHY_REC;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    always_comb begin
        bus_status_o = '0;
        bus_status_o[cwd_pkg::CWD_BIT_WAKE] = state_q.wake_flag;
        bus_status_o[cwd_pkg::CWD_BIT_FAIL] = state_q.fail;
        bus_status_o[cwd_pkg::CWD_BIT_UNID] = state_q.unid;
    end
    assign timer_diag_registers_o = state_q.ident.low_line;
    assign low_power_ctrl_register_o = state_q.ident.high_line;
    assign main_reg_on_o = state_q.main_reg_on;
    assign host_reset_n_o = state_q.host_reset_n;
    assign irq_pulse_o = state_q.irq;
endmodule

// >>> sim/cwd_sva.sv
/* Checker on the cwd_top ports: wake reporting and bus line diagnosis.
   Assumes it is bound into cwd_top and inherits its count parameters. */
`timescale 1ns/1ps
module cwd_sva #(
    parameter int SETTLE_CYCLES = 4,
    parameter int ID_CYCLES = 5
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire cwd_pkg::cwd_chip_mode_type chip_mode_i,
    input wire logic bus_sleep_i,
    input wire logic bus_wake_enable_i,
    input wire logic transceive_mode_i,
    input wire logic bus_wake_event_i,
    input wire logic other_wake_event_i,
    input wire logic driver_dominant_i,
    input wire logic phase_valid_i,
    input wire cwd_pkg::cwd_cmp_type cmp_raw_i,
    input wire logic main_reg_on_o,
    input wire logic host_reset_n_o,
    input wire logic irq_pulse_o,
    input wire logic [cwd_pkg::CWD_BUS_REG_W-1:0] bus_status_o,
    input wire logic [cwd_pkg::CWD_LINE_W-1:0] timer_diag_registers_o,
    input wire logic [cwd_pkg::CWD_LINE_W-1:0] low_power_ctrl_register_o
);
    // ==========================================================
    // Dominant samples seen while a failure is flagged
    int dom_cnt_q;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || !bus_status_o[2]) begin
            dom_cnt_q <= 0;
        end else if (phase_valid_i && driver_dominant_i) begin
            dom_cnt_q <= dom_cnt_q + 1;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_stop_irq_pulse: assert property (chip_mode_i == cwd_pkg::CWD_CHIP_STOP && other_wake_event_i |=>
        irq_pulse_o) else $error("no interrupt pulse after stop wake");
    a_irq_only_stop: assert property (irq_pulse_o |-> $past(chip_mode_i) == cwd_pkg::CWD_CHIP_STOP)
        else $error("interrupt pulse outside stop mode");
    a_wake_flag_set: assert property (bus_wake_event_i && bus_sleep_i && bus_wake_enable_i |=>
        bus_status_o[cwd_pkg::CWD_BIT_WAKE]) else $error("wake flag not set");
    a_wake_flag_hold: assert property (bus_status_o[3] && !transceive_mode_i |=> bus_status_o[3])
        else $error("wake flag lost outside transceive mode");
    a_sleep_reg_on: assert property (chip_mode_i == cwd_pkg::CWD_CHIP_SLEEP && other_wake_event_i |=>
        main_reg_on_o) else $error("regulator not on after sleep wake");
    a_release_order: assert property ($rose(host_reset_n_o) |-> $past(main_reg_on_o, 2))
        else $error("host reset released before regulator on");
    a_rec_ground_fail: assert property (phase_valid_i && !driver_dominant_i &&
        ($past(cmp_raw_i, 2) & 6'h30) == 6'h00 |=> bus_status_o[2]) else $error("ground short not flagged");
    a_line_needs_pairs: assert property ($rose(|{timer_diag_registers_o, low_power_ctrl_register_o}) |->
        dom_cnt_q >= ID_CYCLES) else $error("failure identified too early");
    a_ident_clears_unid: assert property (|{timer_diag_registers_o, low_power_ctrl_register_o} |->
        bus_status_o[2] && !bus_status_o[1]) else $error("identified failure with wrong status bits");
    a_unid_needs_fail: assert property (bus_status_o[1] |-> bus_status_o[2])
        else $error("unidentified flag without failure flag");
    a_status_spare: assert property (bus_status_o[7:4] == 4'h0 && bus_status_o[0] == 1'h0)
        else $error("spare status bits set");
endmodule

// >>> sim/cwd_host.sv
/* Host model: on request enters transceive mode and reads the status register.
   Assumes the bench clock; samples requests on the rising edge. */
`timescale 1ns/1ps
module cwd_host (
    input wire logic ref_clk_i,
    input wire logic read_req_i,
    output logic transceive_mode_o,
    output logic bus_reg_read_o
);
    initial begin
        transceive_mode_o = 1'h0;
        bus_reg_read_o = 1'h0;
        forever begin
            @(posedge ref_clk_i);
            if (read_req_i) begin
                @(negedge ref_clk_i);
                transceive_mode_o = 1'h1;
                repeat (2) @(negedge ref_clk_i);
                bus_reg_read_o = 1'h1;
                @(negedge ref_clk_i);
                bus_reg_read_o = 1'h0;
                @(negedge ref_clk_i);
                transceive_mode_o = 1'h0;
            end
        end
    end
endmodule

// >>> sim/tb.sv
/* Self-checking bench for cwd_top with a host model and a bound checker.
   Assumes package, design and sim model files are compiled first. */
`timescale 1ns/1ps
module tb;
    localparam int SETTLE_CYCLES = 4;
    localparam int ID_CYCLES = 5;
    logic ref_clk_i, reset_n_i, bsleep, wen, trx, bwake, owake, rd, dom, pv, req, reg_on, hrst_n, irq;
    cwd_pkg::cwd_chip_mode_type mode;
    cwd_pkg::cwd_cmp_type cmp;
    logic [7:0] status;
    logic [2:0] low_reg, high_reg, line;
    int fails, n_tests;
    logic [5:0] rec_pat [6] = '{6'h00, 6'h00, 6'h3C, 6'h3C, 6'h33, 6'h33};
    logic [5:0] dom_pat [6] = '{6'h10, 6'h00, 6'h1C, 6'h14, 6'h13, 6'h11};
    cwd_top #(.SETTLE_CYCLES(SETTLE_CYCLES), .ID_CYCLES(ID_CYCLES)) dut_u (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .chip_mode_i(mode), .bus_sleep_i(bsleep), .bus_wake_enable_i(wen),
        .transceive_mode_i(trx), .bus_wake_event_i(bwake), .other_wake_event_i(owake), .bus_reg_read_i(rd),
        .driver_dominant_i(dom), .phase_valid_i(pv), .cmp_raw_i(cmp), .main_reg_on_o(reg_on),
        .host_reset_n_o(hrst_n), .irq_pulse_o(irq), .bus_status_o(status), .timer_diag_registers_o(low_reg),
        .low_power_ctrl_register_o(high_reg));
    cwd_host host_u (.ref_clk_i(ref_clk_i), .read_req_i(req), .transceive_mode_o(trx), .bus_reg_read_o(rd));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wake(input logic b);
        bwake = b;
        owake = !b;
        cyc(1);
        bwake = 1'h0;
        owake = 1'h0;
    endtask
    task automatic phase(input logic d, input logic [5:0] p);
        dom = d;
        cmp = p;
        cyc($urandom_range(3, 5));
        pv = 1'h1;
        cyc(1);
        pv = 1'h0;
        cyc(1);
    endtask
    task automatic host_read();
        req = 1'h1;
        cyc(1);
        req = 1'h0;
        cyc(8);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'h0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        cyc(20000);
        fails++;
        summarize();
    end
    // ==========================================================
    // Main sequence
    initial begin
        int q[$];
        int i;
        int k;
        {reset_n_i, bsleep, wen, bwake, owake, dom, pv, req} = 8'h00;
        mode = cwd_pkg::CWD_CHIP_NORMAL;
        cmp = cwd_pkg::CWD_HEALTHY_REC;
        void'($urandom(48));
        cyc(4);
        reset_n_i = 1'h1;
        cyc(1);
        chk({5'h0, reg_on, hrst_n, irq}, 8'h06);
        chk(status, 8'h00);
        mode = cwd_pkg::CWD_CHIP_STOP;
        cyc(1);
        wake(1'h0);
        chk({7'h0, irq}, 8'h01);
        cyc(1);
        {bsleep, wen} = 2'h3;
        wake(1'h1);
        chk({irq, status[6:0]}, 8'h88);
        host_read();
        chk(status, 8'h00);
        mode = cwd_pkg::CWD_CHIP_NORMAL;
        wen = 1'h0;
        wake(1'h1);
        chk({irq, status[6:0]}, 8'h00);
        wen = 1'h1;
        cyc(1);
        wake(1'h1);
        chk({irq, status[6:0]}, 8'h08);
        cyc(10);
        chk(status, 8'h08);
        host_read();
        chk(status, 8'h00);
        mode = cwd_pkg::CWD_CHIP_SLEEP;
        cyc(3);
        chk({6'h0, reg_on, hrst_n}, 8'h00);
        wake(1'h0);
        chk({6'h0, reg_on, hrst_n}, 8'h02);
        k = 0;
        while (hrst_n !== 1'h1 && k < 100) begin
            cyc(1);
            k++;
        end
        chk({6'h0, reg_on, 1'(k == SETTLE_CYCLES + 1)}, 8'h03);
        mode = cwd_pkg::CWD_CHIP_NORMAL;
        cyc(2);
        for (i = 0; i < 6; i++) begin
            q.insert($urandom_range(0, q.size()), i);
        end
        foreach (q[j]) begin
            i = q[j];
            line = 3'h1 << (i / 2);
            phase(1'h0, rec_pat[i]);
            chk(status, 8'h06);
            chk({2'h0, low_reg, high_reg}, 8'h00);
            for (k = 1; k < ID_CYCLES; k++) begin
                phase(1'h1, dom_pat[i]);
                phase(1'h0, rec_pat[i]);
            end
            chk(status, 8'h06);
            phase(1'h1, dom_pat[i]);
            chk({2'h0, low_reg, high_reg}, (i % 2 == 0) ? {2'h0, line, 3'h0} : {5'h0, line});
            chk(status, 8'h04);
            phase(1'h0, cwd_pkg::CWD_HEALTHY_REC);
            phase(1'h1, cwd_pkg::CWD_HEALTHY_DOM);
            chk(status, 8'h00);
            chk({5'h0, low_reg | high_reg}, 8'h00);
        end
        summarize();
    end
endmodule
bind cwd_top cwd_sva #(.SETTLE_CYCLES(SETTLE_CYCLES), .ID_CYCLES(ID_CYCLES)) sva_u (.*);
